// [verilog/crs_pkg.sv]
package crs_pkg;
  // Register file geometry and pointer pair base indices.
  localparam int unsigned REG_COUNT = 32;
  localparam logic [4:0] REG_ADDR_FIRST = 5'h00;
  localparam logic [4:0] REG_ADDR_LAST = 5'h1f;
  localparam logic [4:0] PTR_X_LOW = 5'h1a;
  localparam logic [4:0] PTR_Y_LOW = 5'h1c;
  localparam logic [4:0] PTR_Z_LOW = 5'h1e;
  // I/O-space offsets of the stack pointer bytes.
  localparam logic [5:0] STACK_PTR_LOW_OFS = 6'h3d;
  localparam logic [5:0] STACK_PTR_HIGH_OFS = 6'h3e;
  // Stack pointer reset value: last internal SRAM address.
  localparam logic [15:0] LAST_SRAM_ADDRESS = 16'h08ff;
  // Global interrupt enable position in the processor status register.
  localparam int unsigned GIE_BIT = 7;
  // Interrupt entry and return length in clock cycles.
  localparam logic [2:0] IRQ_ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] IRQ_RETURN_CYCLES = 3'h4;
  // Stack adjustment sizes.
  localparam logic [15:0] STACK_STEP_BYTE = 16'h0001;
  localparam logic [15:0] STACK_STEP_ADDR = 16'h0002;
  // Pointer addressing modes.
  typedef enum logic [1:0] {
    CRS_PTR_DISP = 2'h0,
    CRS_PTR_POSTINC = 2'h1,
    CRS_PTR_PREDEC = 2'h2
  } crs_ptr_mode_t;
  // Stack operations.
  typedef enum logic [2:0] {
    CRS_STK_NONE = 3'h0,
    CRS_STK_PUSH = 3'h1,
    CRS_STK_POP = 3'h2,
    CRS_STK_CALL = 3'h3,
    CRS_STK_RET = 3'h4
  } crs_stk_op_t;
endpackage

// [verilog/crs_regfile.sv]
`timescale 1ns/1ps
module crs_regfile
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [4:0] rd_a_addr,
  output logic [7:0] rd_a_data,
  input wire logic [4:0] rd_b_addr,
  output logic [7:0] rd_b_data,
  input wire logic [1:0] rd_w_sel,
  output logic [15:0] rd_w_data,
  input wire logic wr8_en,
  input wire logic [4:0] wr8_addr,
  input wire logic [7:0] wr8_data,
  input wire logic wr16_en,
  input wire logic [4:0] wr16_addr,
  input wire logic [15:0] wr16_data,
  input wire logic wrp_en,
  input wire logic [1:0] wrp_sel,
  input wire logic [15:0] wrp_data
);
  logic [7:0] regs_q [crs_pkg::REG_COUNT];

  function automatic logic [4:0] pair_base(input logic [1:0] sel);
    pair_base = (sel == 2'h1) ? crs_pkg::PTR_Y_LOW :
                (sel == 2'h2) ? crs_pkg::PTR_Z_LOW : crs_pkg::PTR_X_LOW;
  endfunction

  wire [4:0] w_lo = pair_base(rd_w_sel);
  wire [4:0] p_lo = pair_base(wrp_sel);
  wire [4:0] p16_lo = {wr16_addr[4:1], 1'b0};

  // Reads are combinational so operands and write-back share one cycle.
  assign rd_a_data = regs_q[rd_a_addr];
  assign rd_b_data = regs_q[rd_b_addr];
  assign rd_w_data = {regs_q[w_lo + 5'h01], regs_q[w_lo]};

  // Later writes in this block take precedence: pointer update last.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < crs_pkg::REG_COUNT; i++)
        regs_q[i] <= 8'h00;
    end
    else
    begin
      if (wr8_en)
        regs_q[wr8_addr] <= wr8_data;
      if (wr16_en)
      begin
        regs_q[p16_lo] <= wr16_data[7:0];
        regs_q[p16_lo + 5'h01] <= wr16_data[15:8];
      end
      if (wrp_en)
      begin
        regs_q[p_lo] <= wrp_data[7:0];
        regs_q[p_lo + 5'h01] <= wrp_data[15:8];
      end
    end
  end
endmodule

// [verilog/crs_core_ctrl.sv]
`timescale 1ns/1ps
module crs_core_ctrl
#(
  parameter int unsigned NUM_IRQ = 8,
  parameter int unsigned PC_W = 14,
  parameter logic [PC_W-1:0] BOOT_START = 14'h3800,
  parameter logic [PC_W-1:0] VECTOR_STRIDE = 14'h0002
)
(
  input wire logic clock,
  input wire logic nrst,
  // Register file ports from the execute stage.
  input wire logic [4:0] rd_a_addr,
  output logic [7:0] rd_a_data,
  input wire logic [4:0] rd_b_addr,
  output logic [7:0] rd_b_data,
  input wire logic [1:0] rd_w_sel,
  output logic [15:0] rd_w_data,
  input wire logic wr8_en,
  input wire logic [4:0] wr8_addr,
  input wire logic [7:0] wr8_data,
  input wire logic wr16_en,
  input wire logic [4:0] wr16_addr,
  input wire logic [15:0] wr16_data,
  // Indirect addressing request.
  input wire logic ptr_req,
  input wire logic [1:0] ptr_sel,
  input wire logic [1:0] ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_addr_q,
  // Stack operations and I/O access to the stack pointer.
  input wire logic [2:0] stack_op,
  input wire logic io_we,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  output logic [15:0] stack_addr_q,
  output logic stack_we_q,
  // Global enable control from the instruction decoder.
  input wire logic instr_done,
  input wire logic gie_set,
  input wire logic gie_clear,
  input wire logic return_from_interrupt_start,
  // Interrupt sources.
  input wire logic [NUM_IRQ-1:0] irq_event,
  input wire logic [NUM_IRQ-1:0] irq_level_mask,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_flag_w1c,
  output logic [NUM_IRQ-1:0] irq_flags_q,
  // Vector placement and protection.
  input wire logic vector_select_bit,
  input wire logic boot_reset_fuse,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  input wire logic [PC_W-1:0] pc,
  // Interrupt entry towards fetch.
  output logic irq_take_q,
  output logic [PC_W-1:0] irq_vector_q,
  output logic [PC_W-1:0] reset_vector_q,
  output logic entry_busy_q,
  output logic ret_busy_q,
  output logic gie_q
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic wrp_en;
  logic [15:0] wrp_data;

  // Undivided clock; reads and write-back land in one cycle.
  crs_regfile u_regfile
  (
    .clock(clock),
    .nrst(nrst),
    .rd_a_addr(rd_a_addr),
    .rd_a_data(rd_a_data),
    .rd_b_addr(rd_b_addr),
    .rd_b_data(rd_b_data),
    .rd_w_sel(ptr_req ? ptr_sel : rd_w_sel),
    .rd_w_data(rd_w_data),
    .wr8_en(wr8_en),
    .wr8_addr(wr8_addr),
    .wr8_data(wr8_data),
    .wr16_en(wr16_en),
    .wr16_addr(wr16_addr),
    .wr16_data(wr16_data),
    .wrp_en(wrp_en),
    .wrp_sel(ptr_sel),
    .wrp_data(wrp_data)
  );

  // ----------------------------------------------------------------
  // Indirect addressing
  // ----------------------------------------------------------------
  wire [15:0] ptr_base = rd_w_data;
  wire ptr_inc = ptr_req && (ptr_mode == crs_pkg::CRS_PTR_POSTINC);
  wire ptr_dec = ptr_req && (ptr_mode == crs_pkg::CRS_PTR_PREDEC);
  wire [15:0] ptr_dec_val = ptr_base - 16'h0001;
  wire [15:0] ptr_addr_d = ptr_dec ? ptr_dec_val :
                           ptr_inc ? ptr_base :
                           ptr_base + {10'h000, ptr_disp};
  assign wrp_en = ptr_inc || ptr_dec;
  assign wrp_data = ptr_dec ? ptr_dec_val : ptr_base + 16'h0001;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      ptr_addr_q <= 16'h0000;
    else if (ptr_req)
      ptr_addr_q <= ptr_addr_d;
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic [2:0] entry_cnt_q;
  logic [2:0] ret_cnt_q;
  wire entry_start;
  wire sp_low_hit = (io_addr == crs_pkg::STACK_PTR_LOW_OFS);
  wire sp_high_hit = (io_addr == crs_pkg::STACK_PTR_HIGH_OFS);
  wire is_push = (stack_op == crs_pkg::CRS_STK_PUSH);
  wire is_pop = (stack_op == crs_pkg::CRS_STK_POP);
  wire is_call = (stack_op == crs_pkg::CRS_STK_CALL) || entry_start;
  wire is_ret = (stack_op == crs_pkg::CRS_STK_RET) || return_from_interrupt_start;
  wire [15:0] sp_pop = sp_q + crs_pkg::STACK_STEP_BYTE;

  // Downward stack; the pointer always addresses the free top slot.
  always_comb
  begin
    sp_d = sp_q;
    if (is_call)
      sp_d = sp_q - crs_pkg::STACK_STEP_ADDR;
    else if (is_ret)
      sp_d = sp_q + crs_pkg::STACK_STEP_ADDR;
    else if (is_push)
      sp_d = sp_q - crs_pkg::STACK_STEP_BYTE;
    else if (is_pop)
      sp_d = sp_pop;
    else if (io_we && sp_low_hit)
      sp_d = {sp_q[15:8], io_wdata};
    else if (io_we && sp_high_hit)
      sp_d = {io_wdata, sp_q[7:0]};
  end

  // Push writes at the current pointer; pop reads after incrementing.
  wire [15:0] stack_addr_d = is_pop ? sp_pop : sp_q;
  wire [7:0] io_rdata_d = sp_low_hit ? sp_q[7:0] :
                          sp_high_hit ? sp_q[15:8] : 8'h00;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      sp_q <= crs_pkg::LAST_SRAM_ADDRESS;
    else
      sp_q <= sp_d;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      stack_addr_q <= crs_pkg::LAST_SRAM_ADDRESS;
      stack_we_q <= 1'b0;
      io_rdata_q <= 8'h00;
    end
    else
    begin
      stack_addr_q <= stack_addr_d;
      stack_we_q <= is_push || is_call;
      io_rdata_q <= io_rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] ev_s1_q;
  logic [NUM_IRQ-1:0] ev_s2_q;
  logic [NUM_IRQ-1:0] ev_s3_q;
  logic [NUM_IRQ-1:0] take_onehot;
  logic [NUM_IRQ-1:0] flags_d;
  wire [NUM_IRQ-1:0] ev_rise = ev_s2_q & ~ev_s3_q;

  // Sources are asynchronous, so they pass two flops before use.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
    end
    else
    begin
      ev_s1_q <= irq_event;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  // A new event beats a clear in the same cycle so it is never lost.
  assign flags_d = ((irq_flags_q & ~irq_level_mask & ~irq_flag_w1c
                    & ~(take_onehot & ~irq_level_mask))
                    | (ev_rise & ~irq_level_mask))
                   | (ev_s2_q & irq_level_mask);

  always_ff @(posedge clock)
  begin
    if (!nrst)
      irq_flags_q <= '0;
    else
      irq_flags_q <= flags_d;
  end

  // ----------------------------------------------------------------
  // Acceptance and priority
  // ----------------------------------------------------------------
  logic gie_d;
  logic gap_q;
  wire in_boot = (pc >= BOOT_START);
  wire vec_in_boot = vector_select_bit;
  // Lock bits block servicing across the section boundary.
  wire locked = (app_section_lock_bit && !in_boot && vec_in_boot) ||
                (boot_section_lock_bit && in_boot && !vec_in_boot);
  // Level sources track the synchronised condition directly.
  wire [NUM_IRQ-1:0] live = (irq_flags_q & ~irq_level_mask) |
                            (ev_s2_q & irq_level_mask);
  wire [NUM_IRQ-1:0] pending = live & irq_enable;
  wire idle = !entry_busy_q && !ret_busy_q;
  // Clear wins in its own cycle; set waits one instruction via gap.
  assign entry_start = (|pending) && gie_q && !gie_clear
                       && !gap_q && instr_done && idle
                       && !locked;

  function automatic logic [NUM_IRQ-1:0] lowest(input logic [NUM_IRQ-1:0] v);
    logic [NUM_IRQ-1:0] r;
    r = v & (~v + {{(NUM_IRQ-1){1'b0}}, 1'b1});
    return r;
  endfunction

  function automatic logic [PC_W-1:0] index_of(input logic [NUM_IRQ-1:0] v);
    logic [PC_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_IRQ; i++)
      if (v[i])
        r = PC_W'(i + 1);
    return r;
  endfunction

  assign take_onehot = entry_start ? lowest(pending) : '0;
  wire [PC_W-1:0] vec_base = vector_select_bit ? BOOT_START : '0;
  wire [PC_W-1:0] vec_d = vec_base +
                          PC_W'(index_of(take_onehot) * VECTOR_STRIDE);

  // Status bit 7 image kept here as the single global enable copy.
  always_comb
  begin
    gie_d = gie_q;
    if (entry_start)
      gie_d = 1'b0;
    else if (gie_clear)
      gie_d = 1'b0;
    else if (ret_busy_q && ret_cnt_q == 3'h1)
      gie_d = 1'b1;
    else if (gie_set)
      gie_d = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      gie_q <= 1'b0;
      gap_q <= 1'b0;
      irq_take_q <= 1'b0;
      irq_vector_q <= '0;
    end
    else
    begin
      gie_q <= gie_d;
      // Blocks entry until one instruction retires after set or return.
      if ((gie_set && !gie_q) || (ret_busy_q && ret_cnt_q == 3'h1))
        gap_q <= 1'b1;
      else if (instr_done)
        gap_q <= 1'b0;
      irq_take_q <= entry_start;
      if (entry_start)
        irq_vector_q <= vec_d;
    end
  end

  // Reset vector is caught after release, not under reset.
  always_ff @(posedge clock)
  begin
    if (!nrst)
      reset_vector_q <= '0;
    else
      reset_vector_q <= boot_reset_fuse ? BOOT_START : '0;
  end

  // ----------------------------------------------------------------
  // Entry and return sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      entry_cnt_q <= 3'h0;
      entry_busy_q <= 1'b0;
      ret_cnt_q <= 3'h0;
      ret_busy_q <= 1'b0;
    end
    else
    begin
      // Entry only starts on instr_done, so a multi-cycle op finishes.
      if (entry_start)
      begin
        entry_cnt_q <= crs_pkg::IRQ_ENTRY_CYCLES;
        entry_busy_q <= 1'b1;
      end
      else if (entry_busy_q)
      begin
        entry_cnt_q <= entry_cnt_q - 3'h1;
        entry_busy_q <= (entry_cnt_q != 3'h1);
      end
      if (return_from_interrupt_start && !ret_busy_q)
      begin
        ret_cnt_q <= crs_pkg::IRQ_RETURN_CYCLES;
        ret_busy_q <= 1'b1;
      end
      else if (ret_busy_q)
      begin
        ret_cnt_q <= ret_cnt_q - 3'h1;
        ret_busy_q <= (ret_cnt_q != 3'h1);
      end
    end
  end

  // Status register save/restore is left to handler software.
endmodule

// [verification/crs_core_ctrl_assertions.sv]
`timescale 1ns/1ps
module crs_core_ctrl_assertions
#(
  parameter int unsigned NUM_IRQ = 8
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] stack_op,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_rdata_q,
  input wire logic [15:0] stack_addr_q,
  input wire logic stack_we_q,
  input wire logic instr_done,
  input wire logic gie_set,
  input wire logic gie_clear,
  input wire logic return_from_interrupt_start,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_level_mask,
  input wire logic [NUM_IRQ-1:0] irq_flag_w1c,
  input wire logic [NUM_IRQ-1:0] irq_flags_q,
  input wire logic irq_take_q,
  input wire logic entry_busy_q,
  input wire logic ret_busy_q,
  input wire logic gie_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Stack checks only hold when no entry or return competes for the
  // pointer, since those win the arbitration.
  wire quiet = !instr_done && !return_from_interrupt_start && !ret_busy_q && !entry_busy_q;
  logic [NUM_IRQ-1:0] held_q;
  always_ff @(posedge clock)
  begin
    if (!nrst)
      held_q <= '0;
    else
      held_q <= irq_flags_q & ~irq_enable & ~irq_level_mask & ~irq_flag_w1c;
  end
  sequence s_push2;
    stack_op == crs_pkg::CRS_STK_PUSH && quiet ##1
      stack_op == crs_pkg::CRS_STK_PUSH && quiet;
  endsequence
  sequence s_entry_walk;
    entry_busy_q [*4] ##1 !entry_busy_q;
  endsequence
  sequence s_ret_walk;
    ret_busy_q [*4] ##1 (!ret_busy_q && gie_q);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_take_gated:
    assert property (irq_take_q |-> $past(gie_q) && $past(instr_done))
    else $error("interrupt taken without global enable");
  a_take_clears:
    assert property (irq_take_q |-> !gie_q)
    else $error("global enable still set after entry");
  a_entry_walk:
    assert property (irq_take_q |-> s_entry_walk)
    else $error("entry length wrong");
  a_ret_walk:
    assert property (return_from_interrupt_start && !ret_busy_q && !entry_busy_q
      |=> s_ret_walk)
    else $error("return length or enable wrong");
  a_push_step:
    assert property (s_push2 |=> stack_we_q &&
      stack_addr_q == $past(stack_addr_q) - crs_pkg::STACK_STEP_BYTE)
    else $error("push address step wrong");
  a_pop_read:
    assert property (stack_op == crs_pkg::CRS_STK_POP && quiet
      |=> !stack_we_q)
    else $error("pop wrote memory");
  a_flag_held:
    assert property ((held_q & ~irq_flags_q) == '0)
    else $error("disabled flag lost");
  a_io_unmapped:
    assert property (io_addr != crs_pkg::STACK_PTR_LOW_OFS &&
      io_addr != crs_pkg::STACK_PTR_HIGH_OFS |=> io_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_sei_gap:
    assert property ($rose(gie_q) |-> !irq_take_q ##1 !irq_take_q)
    else $error("interrupt taken with no instruction between");
  a_cli_now:
    assert property (gie_clear && !gie_set && !return_from_interrupt_start && !ret_busy_q
      |=> !gie_q && !irq_take_q)
    else $error("global disable late");
endmodule

bind crs_core_ctrl crs_core_ctrl_assertions #(.NUM_IRQ(NUM_IRQ)) chk_u (
  .clock, .nrst, .stack_op, .io_addr, .io_rdata_q, .stack_addr_q,
  .stack_we_q, .instr_done, .gie_set, .gie_clear, .return_from_interrupt_start,
  .irq_enable, .irq_level_mask, .irq_flag_w1c, .irq_flags_q,
  .irq_take_q, .entry_busy_q, .ret_busy_q, .gie_q);

// [verification/crs_src_model.sv]
`timescale 1ns/1ps
module crs_src_model
(
  input wire logic clock,
  input wire logic [7:0] fire,
  output logic [7:0] irq_event
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  // A request is stretched to two cycles so that the receiving
  // synchroniser cannot miss it, whatever its phase.
  always_ff @(posedge clock)
  begin
    s1_q <= fire;
    s2_q <= s1_q;
  end
  assign irq_event = s1_q | s2_q;
endmodule

// [verification/crs_core_ctrl_test.sv]
`timescale 1ns/1ps
module crs_core_ctrl_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] rd_a_addr = 5'h00, rd_b_addr = 5'h00;
  logic [4:0] wr8_addr = 5'h00, wr16_addr = 5'h00;
  logic [1:0] rd_w_sel = 2'h0, ptr_sel = 2'h0, ptr_mode = 2'h0;
  logic wr8_en = 1'b0, wr16_en = 1'b0, ptr_req = 1'b0, io_we = 1'b0;
  logic instr_done = 1'b0, gie_set = 1'b0, gie_clear = 1'b0;
  logic return_from_interrupt_start = 1'b0, vector_select_bit = 1'b0;
  logic boot_reset_fuse = 1'b0, app_section_lock_bit = 1'b0;
  logic boot_section_lock_bit = 1'b0;
  logic [7:0] irq_level_mask = 8'h00;
  logic [13:0] pc = 14'h0000;
  logic [7:0] wr8_data = 8'h00, io_wdata = 8'h00;
  logic [15:0] wr16_data = 16'h0000;
  logic [5:0] ptr_disp = 6'h00, io_addr = 6'h00;
  logic [2:0] stack_op = 3'h0;
  logic [7:0] irq_enable = 8'h00, irq_flag_w1c = 8'h00, fire = 8'h00;
  logic [7:0] rd_a_data, rd_b_data, io_rdata_q, irq_flags_q, irq_event;
  logic [15:0] rd_w_data, ptr_addr_q, stack_addr_q;
  logic [13:0] irq_vector_q, reset_vector_q;
  logic stack_we_q, irq_take_q, entry_busy_q, ret_busy_q, gie_q;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  crs_core_ctrl dut_u (.clock, .nrst, .rd_a_addr, .rd_a_data, .rd_b_addr,
    .rd_b_data, .rd_w_sel, .rd_w_data, .wr8_en, .wr8_addr, .wr8_data,
    .wr16_en, .wr16_addr, .wr16_data, .ptr_req, .ptr_sel, .ptr_mode,
    .ptr_disp, .ptr_addr_q, .stack_op, .io_we, .io_addr, .io_wdata,
    .io_rdata_q, .stack_addr_q, .stack_we_q, .instr_done, .gie_set,
    .gie_clear, .return_from_interrupt_start, .irq_event, .irq_level_mask,
    .irq_enable, .irq_flag_w1c, .irq_flags_q, .vector_select_bit,
    .boot_reset_fuse, .app_section_lock_bit,
    .boot_section_lock_bit, .pc, .irq_take_q,
    .irq_vector_q, .reset_vector_q, .entry_busy_q, .ret_busy_q, .gie_q);
  crs_src_model src_u (.clock, .fire, .irq_event);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fail_count = fail_count + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic io_rd(input logic [5:0] a, input logic [7:0] e);
    io_addr = a;
    tick(1);
    chk("io_rdata_q", {8'h00, io_rdata_q}, {8'h00, e});
  endtask
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    tick(1);
    io_we = 1'b0;
    tick(1);
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    wr8_addr = a;
    wr8_data = d;
    wr8_en = 1'b1;
    tick(1);
    wr8_en = 1'b0;
    tick(1);
  endtask
  task automatic stk(input logic [2:0] op, input logic [15:0] e);
    stack_op = op;
    tick(1);
    chk("stack_addr_q", stack_addr_q, e);
  endtask
  // One instruction retires per cycle; the first after an enable or a
  // return must retire before the entry is accepted.
  task automatic take_irq(input logic [13:0] v);
    int n;
    n = 0;
    instr_done = 1'b1;
    tick(1);
    while (irq_take_q !== 1'b1 && n < 6)
    begin
      n = n + 1;
      tick(1);
    end
    instr_done = 1'b0;
    chk("gap", n[15:0], 16'h0001);
    chk("irq_vector_q", {2'h0, irq_vector_q}, {2'h0, v});
    chk("gie_q", {15'h0, gie_q}, 16'h0000);
    tick(4);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    wr8(5'h1f, 8'h12);
    wr8(5'h1e, 8'h34);
    wr8(5'h05, 8'ha5);
    rd_a_addr = 5'h05;
    rd_w_sel = 2'h2;
    tick(1);
    chk("rd_a_data", {8'h00, rd_a_data}, 16'h00a5);
    chk("rd_w_data", rd_w_data, 16'h1234);
    wr16_addr = 5'h1c;
    wr16_data = 16'hbeef;
    wr16_en = 1'b1;
    tick(1);
    wr16_en = 1'b0;
    rd_a_addr = 5'h1c;
    rd_b_addr = 5'h1d;
    rd_w_sel = 2'h1;
    tick(1);
    chk("rd_a_data", {rd_b_data, rd_a_data}, 16'hbeef);
  endtask
  task automatic t_ptr();
    ptr_req = 1'b1;
    ptr_sel = 2'h1;
    ptr_disp = 6'h3f;
    ptr_mode = crs_pkg::CRS_PTR_DISP;
    tick(1);
    chk("ptr_addr_q", ptr_addr_q, 16'hbf2e);
    ptr_mode = crs_pkg::CRS_PTR_POSTINC;
    tick(1);
    chk("ptr_addr_q", ptr_addr_q, 16'hbeef);
    ptr_mode = crs_pkg::CRS_PTR_PREDEC;
    tick(1);
    chk("ptr_addr_q", ptr_addr_q, 16'hbeef);
    ptr_req = 1'b0;
  endtask
  task automatic t_stack();
    io_wr(crs_pkg::STACK_PTR_HIGH_OFS, 8'h04);
    io_wr(crs_pkg::STACK_PTR_LOW_OFS, 8'h00);
    stack_op = crs_pkg::CRS_STK_PUSH;
    tick(1);
    chk("stack_we_q", {15'h0, stack_we_q}, 16'h0001);
    stk(crs_pkg::CRS_STK_PUSH, 16'h03ff);
    stk(crs_pkg::CRS_STK_CALL, 16'h03fe);
    stk(crs_pkg::CRS_STK_POP, 16'h03fd);
    stack_op = crs_pkg::CRS_STK_RET;
    tick(1);
    stack_op = crs_pkg::CRS_STK_NONE;
    io_rd(crs_pkg::STACK_PTR_LOW_OFS, 8'hff);
    io_rd(crs_pkg::STACK_PTR_HIGH_OFS, 8'h03);
  endtask
  task automatic t_irq();
    fire = 8'h24;
    tick(1);
    fire = 8'h00;
    tick(5);
    chk("irq_flags_q", {8'h00, irq_flags_q}, 16'h0024);
    irq_flag_w1c = 8'h04;
    tick(1);
    irq_flag_w1c = 8'h00;
    chk("irq_flags_q", {8'h00, irq_flags_q}, 16'h0020);
    fire = 8'h04;
    tick(1);
    fire = 8'h00;
    tick(5);
    irq_enable = 8'h24;
    gie_set = 1'b1;
    tick(1);
    gie_set = 1'b0;
    instr_done = 1'b1;
    tick(1);
    gie_clear = 1'b1;
    tick(1);
    instr_done = 1'b0;
    gie_clear = 1'b0;
    chk("irq_take_q", {15'h0, irq_take_q}, 16'h0000);
    chk("gie_q", {15'h0, gie_q}, 16'h0000);
    gie_set = 1'b1;
    tick(1);
    gie_set = 1'b0;
    take_irq(14'h0006);
    chk("irq_flags_q", {8'h00, irq_flags_q}, 16'h0020);
    io_rd(crs_pkg::STACK_PTR_LOW_OFS, 8'hfd);
    return_from_interrupt_start = 1'b1;
    tick(1);
    return_from_interrupt_start = 1'b0;
    tick(5);
    chk("gie_q", {15'h0, gie_q}, 16'h0001);
    io_rd(crs_pkg::STACK_PTR_LOW_OFS, 8'hff);
    vector_select_bit = 1'b1;
    take_irq(14'h380c);
  endtask
  task automatic t_guard();
    boot_reset_fuse = 1'b1;
    irq_level_mask = 8'h01;
    fire = 8'h01;
    tick(1);
    fire = 8'h00;
    chk("reset_vector_q", {2'h0, reset_vector_q}, 16'h3800);
    tick(3);
    chk("irq_flags_q", {8'h00, irq_flags_q}, 16'h0001);
    tick(2);
    chk("irq_flags_q", {8'h00, irq_flags_q}, 16'h0000);
    irq_level_mask = 8'h00;
    fire = 8'h04;
    tick(1);
    fire = 8'h00;
    app_section_lock_bit = 1'b1;
    gie_set = 1'b1;
    tick(1);
    gie_set = 1'b0;
    instr_done = 1'b1;
    tick(6);
    chk("gie_q", {15'h0, gie_q}, 16'h0001);
    chk("irq_flags_q", {8'h00, irq_flags_q}, 16'h0004);
    app_section_lock_bit = 1'b0;
    boot_section_lock_bit = 1'b1;
    pc = 14'h3800;
    vector_select_bit = 1'b0;
    tick(2);
    chk("gie_q", {15'h0, gie_q}, 16'h0001);
    instr_done = 1'b0;
    boot_section_lock_bit = 1'b0;
    pc = 14'h0000;
    gie_clear = 1'b1;
    tick(1);
    gie_clear = 1'b0;
    gie_set = 1'b1;
    tick(1);
    gie_set = 1'b0;
    take_irq(14'h0006);
  endtask
  initial
  begin
    tick(10);
    nrst = 1'b1;
    io_rd(crs_pkg::STACK_PTR_LOW_OFS,
      crs_pkg::LAST_SRAM_ADDRESS[7:0]);
    io_rd(crs_pkg::STACK_PTR_HIGH_OFS,
      crs_pkg::LAST_SRAM_ADDRESS[15:8]);
    io_rd(6'h10, 8'h00);
    chk("reset_vector_q", {2'h0, reset_vector_q}, 16'h0000);
    t_regs();
    t_ptr();
    t_stack();
    t_irq();
    t_guard();
    summarize();
  end
endmodule
